/* File: verilog/rlp_defines.vh */
/*
  Constants for the reset, low-power and peripheral clock gating block:
  register byte addresses, field positions, write masks, reset values
  and the reset stretch count.
  Assumes it is included by its bare name from the design files only.
*/
`ifndef RLP_DEFINES_VH
`define RLP_DEFINES_VH

// register byte addresses
`define RLP_ADDR_GATE_ONE     8'hdb
`define RLP_ADDR_GATE_TWO     8'hdc
`define RLP_ADDR_RESET_CAUSE  8'hdf

// reset values
`define RLP_GATE_RESET        8'h00
`define RLP_CAUSE_RESET       4'h0

// writable bits; reserved bits stay zero
`define RLP_GATE_ONE_WMASK    8'hef
`define RLP_GATE_TWO_WMASK    8'hbf

// first gate register fields
`define RLP_G1_PORT_D         7
`define RLP_G1_PORT_C         6
`define RLP_G1_PORT_B         5
`define RLP_G1_SPI            3
`define RLP_G1_I2C            2
`define RLP_G1_SERIAL_TWO     1
`define RLP_G1_SERIAL_ONE     0

// second gate register fields
`define RLP_G2_BUS_CLK_OFF    7
`define RLP_G2_TIMER_MSB      5
`define RLP_G2_TIMER_LSB      0

// reset cause register fields
`define RLP_CAUSE_PIN         0
`define RLP_CAUSE_WDT         1
`define RLP_CAUSE_RTC         2
`define RLP_CAUSE_DBG         3

// reset stretch, in system clock cycles
`define RLP_STRETCH_CYCLES    9'd257
`define RLP_STRETCH_LAST      9'd256

`endif

/* File: verilog/rlp_sync3.v */
/*
  Three-stage input synchroniser with agreement filter.
  Assumes d is asynchronous to clk; q changes only when the second and
  third stages agree.
*/
`timescale 1ns/100ps
`default_nettype none

module rlp_sync3 #(
  parameter RESET_VAL = 1'b0
)
(
  // clock and reset
  input  wire clk,
  input  wire reset_n,
  // data
  input  wire d,
  output wire q
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  reg q_reg;

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
      q_reg  <= RESET_VAL;
    end
    else
    begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        q_reg <= s3_reg;
    end
  end

  assign q = q_reg;

endmodule

`default_nettype wire

/* File: verilog/rlp_clk_gate.v */
/*
  Glitch-free clock gate cell.
  Assumes en comes from logic on the rising edge of clk; the enable is
  retimed while clk is low so a pulse is never cut short.
*/
`timescale 1ns/100ps
`default_nettype none

module rlp_clk_gate
(
  // clock and reset
  input  wire clk,
  input  wire reset_n,
  // gating
  input  wire en,
  output wire gclk
);

  reg en_low_reg;

  // enable only changes while clk is low
  always @(negedge clk)
  begin
    if (!reset_n)
      en_low_reg <= 1'b1;
    else
      en_low_reg <= en;
  end

  assign gclk = clk & en_low_reg;

endmodule

`default_nettype wire

/* File: verilog/rlp_reset_power.v */
/*
  Reset controller, sleep/halt sequencer and peripheral clock gating.
  Holds the two gate registers and a reset cause register on a plain
  strobe bus with read data one cycle after the read strobe.
  Assumes CLK_SYS is the always-on control clock of this block; the
  primary oscillator and system clock it switches off are downstream.
  Reset pin, watchdog timeout and alarm are asynchronous and synchronised
  here; debug reset, instructions and interrupts are on CLK_SYS.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rlp_defines.vh"

module rlp_reset_power #(
  parameter ADDR_W  = 8,
  parameter NUM_TMR = 6
)
(
  // clock and logic reset
  input  wire                CLK_SYS,
  input  wire                RESET_N,
  // reset sources
  input  wire                RST_PIN_N,
  input  wire                WDT_TIMEOUT,
  input  wire                WDT_RESET_MODE,
  input  wire                WDT_USES_32K,
  input  wire                RTC_ALARM,
  input  wire                DBG_RESET,
  // core requests and wake events
  input  wire                SLEEP_INSTRUCTION,
  input  wire                HALT_INSTRUCTION,
  input  wire                NMI_REQ,
  input  wire                INT_REQ,
  // register port
  input  wire [ADDR_W-1:0]   REG_ADDR,
  input  wire [7:0]          REG_WR_DATA,
  input  wire                REG_WR_STB,
  input  wire                REG_RD_STB,
  output wire [7:0]          REG_RD_DATA,
  // system reset and power control
  output wire                SYS_RESET_N,
  output wire                PRIMARY_OSC_EN,
  output wire                SYS_CLK_EN,
  output wire                CPU_IDLE,
  output wire                PC_FREEZE,
  output wire                OSC32K_EN,
  output wire                RTC_32K_CLK_EN,
  output wire                WDT_32K_CLK_EN,
  // peripheral clocks and access enables
  output wire [6:0]          PERIPH_CLK,
  output wire [NUM_TMR-1:0]  TIMER_CLK,
  output wire [6:0]          PERIPH_ACCESS_EN,
  output wire [NUM_TMR-1:0]  TIMER_ACCESS_EN,
  output wire [2:0]          PORT_ALT_FUNC_OK,
  // bus clock output pin
  output wire                BUS_CLK_OUT,
  output wire                BUS_CLK_OE
);

  localparam [1:0] ST_RUN   = 2'd0;
  localparam [1:0] ST_HALT  = 2'd1;
  localparam [1:0] ST_SLEEP = 2'd2;

  localparam [ADDR_W-1:0] ADDR_G1 = `RLP_ADDR_GATE_ONE;
  localparam [ADDR_W-1:0] ADDR_G2 = `RLP_ADDR_GATE_TWO;
  localparam [ADDR_W-1:0] ADDR_RC = `RLP_ADDR_RESET_CAUSE;

  // synchronised asynchronous sources
  wire       pin_rst_n_s;
  wire       wdt_to_s;
  wire       rtc_alarm_s;

  // reset merge
  wire       sleeping;
  wire       src_pin;
  wire       src_wdt;
  wire       src_rtc;
  wire       src_dbg;
  wire       any_src;
  wire [3:0] src_vec;

  // state
  reg  [8:0] stretch_cnt_reg;
  reg        sys_rst_n_reg;
  reg  [3:0] cause_reg;
  reg  [1:0] lp_state_reg;
  reg  [1:0] lp_state_next;
  reg        osc_en_reg;
  reg        sys_clk_en_reg;
  reg        cpu_idle_reg;
  reg        pc_freeze_reg;
  reg        osc32k_en_reg;
  reg        rtc_clk_en_reg;
  reg        wdt_clk_en_reg;

  // registers
  reg  [7:0] gate_one_reg;
  reg  [7:0] gate_two_reg;
  reg  [7:0] rd_data_reg;
  reg  [7:0] rd_data_next;

  // access enables and bus clock pin
  reg  [6:0]         periph_acc_reg;
  reg  [NUM_TMR-1:0] timer_acc_reg;
  reg  [2:0]         port_alt_reg;
  reg                bus_clk_oe_reg;

  wire [6:0]         periph_run;
  wire [NUM_TMR-1:0] timer_run;
  wire               wr_g1;
  wire               wr_g2;

  // pin resets and slow-domain events
  rlp_sync3 #(
    .RESET_VAL (1'b0)
  ) u_sync_pin (
    .clk     (CLK_SYS),
    .reset_n (RESET_N),
    .d       (RST_PIN_N),
    .q       (pin_rst_n_s)
  );

  rlp_sync3 #(
    .RESET_VAL (1'b0)
  ) u_sync_wdt (
    .clk     (CLK_SYS),
    .reset_n (RESET_N),
    .d       (WDT_TIMEOUT),
    .q       (wdt_to_s)
  );

  rlp_sync3 #(
    .RESET_VAL (1'b0)
  ) u_sync_rtc (
    .clk     (CLK_SYS),
    .reset_n (RESET_N),
    .d       (RTC_ALARM),
    .q       (rtc_alarm_s)
  );

  assign sleeping = (lp_state_reg == ST_SLEEP);

  // a watchdog on the system clock cannot tick in sleep
  assign src_pin = ~pin_rst_n_s;
  assign src_wdt = wdt_to_s & WDT_RESET_MODE
                 & (~sleeping | WDT_USES_32K);
  // the alarm is a reset source only while asleep
  assign src_rtc = rtc_alarm_s & sleeping;
  assign src_dbg = DBG_RESET;
  assign any_src = src_pin | src_wdt | src_rtc | src_dbg;

  assign src_vec = {src_dbg, src_rtc, src_wdt, src_pin};

  // reset stretch: counting begins at the first edge with no source
  always @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      stretch_cnt_reg <= 9'd0;
      sys_rst_n_reg   <= 1'b0;
    end
    else if (any_src)
    begin
      stretch_cnt_reg <= 9'd0;
      sys_rst_n_reg   <= 1'b0;
    end
    else if (!sys_rst_n_reg)
    begin
      if (stretch_cnt_reg == `RLP_STRETCH_LAST)
      begin
        stretch_cnt_reg <= 9'd0;
        sys_rst_n_reg   <= 1'b1;
      end
      else
        stretch_cnt_reg <= stretch_cnt_reg + 9'd1;
    end
  end

  // reset cause: restarts on a fresh reset, accumulates while held
  always @(posedge CLK_SYS)
  begin
    if (!RESET_N)
      cause_reg <= `RLP_CAUSE_RESET;
    else if (any_src && sys_rst_n_reg)
      cause_reg <= src_vec;
    else if (any_src)
      cause_reg <= cause_reg | src_vec;
  end

  // low-power sequencer
  always @*
  begin
    lp_state_next = lp_state_reg;
    case (lp_state_reg)
      ST_RUN:
      begin
        if (SLEEP_INSTRUCTION)
          lp_state_next = ST_SLEEP;
        else if (HALT_INSTRUCTION)
          lp_state_next = ST_HALT;
      end
      ST_HALT:
      begin
        if (NMI_REQ || INT_REQ || wdt_to_s || any_src)
          lp_state_next = ST_RUN;
      end
      ST_SLEEP:
      begin
        // no interrupt wakes sleep; only the reset path below does
        lp_state_next = ST_SLEEP;
      end
      default:
      begin
        lp_state_next = ST_RUN;
      end
    endcase
    if (any_src || !sys_rst_n_reg)
      lp_state_next = ST_RUN;
  end

  always @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      lp_state_reg   <= ST_RUN;
      osc_en_reg     <= 1'b1;
      sys_clk_en_reg <= 1'b1;
      cpu_idle_reg   <= 1'b0;
      pc_freeze_reg  <= 1'b0;
      osc32k_en_reg  <= 1'b1;
      rtc_clk_en_reg <= 1'b1;
      wdt_clk_en_reg <= 1'b0;
    end
    else
    begin
      lp_state_reg   <= lp_state_next;
      // halt keeps both running; sleep stops both
      osc_en_reg     <= (lp_state_next != ST_SLEEP);
      sys_clk_en_reg <= (lp_state_next != ST_SLEEP);
      cpu_idle_reg   <= (lp_state_next != ST_RUN);
      pc_freeze_reg  <= (lp_state_next != ST_RUN);
      osc32k_en_reg  <= 1'b1;
      rtc_clk_en_reg <= 1'b1;
      wdt_clk_en_reg <= WDT_USES_32K;
    end
  end

  // register writes
  assign wr_g1 = REG_WR_STB && (REG_ADDR == ADDR_G1);
  assign wr_g2 = REG_WR_STB && (REG_ADDR == ADDR_G2);

  always @(posedge CLK_SYS)
  begin
    if (!RESET_N || !sys_rst_n_reg)
    begin
      gate_one_reg <= `RLP_GATE_RESET;
      gate_two_reg <= `RLP_GATE_RESET;
    end
    else
    begin
      if (wr_g1)
        gate_one_reg <= REG_WR_DATA & `RLP_GATE_ONE_WMASK;
      if (wr_g2)
        gate_two_reg <= REG_WR_DATA & `RLP_GATE_TWO_WMASK;
    end
  end

  // read data stands for one cycle only; unmapped reads give zero
  always @*
  begin
    rd_data_next = 8'h00;
    if (REG_RD_STB)
    begin
      case (REG_ADDR)
        ADDR_G1:
        begin
          rd_data_next = gate_one_reg;
        end
        ADDR_G2:
        begin
          rd_data_next = gate_two_reg;
        end
        ADDR_RC:
        begin
          rd_data_next = {4'h0, cause_reg};
        end
        default:
        begin
          rd_data_next = 8'h00;
        end
      endcase
    end
  end

  always @(posedge CLK_SYS)
  begin
    if (!RESET_N)
      rd_data_reg <= 8'h00;
    else
      rd_data_reg <= rd_data_next;
  end

  // per-peripheral run enables, ordered as PERIPH_CLK
  assign periph_run = ~{gate_one_reg[`RLP_G1_PORT_D],
                        gate_one_reg[`RLP_G1_PORT_C],
                        gate_one_reg[`RLP_G1_PORT_B],
                        gate_one_reg[`RLP_G1_SPI],
                        gate_one_reg[`RLP_G1_I2C],
                        gate_one_reg[`RLP_G1_SERIAL_TWO],
                        gate_one_reg[`RLP_G1_SERIAL_ONE]};
  assign timer_run  =
    ~gate_two_reg[`RLP_G2_TIMER_LSB +: NUM_TMR];

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1)
    begin : g_periph_gate
      rlp_clk_gate u_gate (
        .clk     (CLK_SYS),
        .reset_n (RESET_N),
        .en      (periph_run[gi]),
        .gclk    (PERIPH_CLK[gi])
      );
    end
    for (gi = 0; gi < NUM_TMR; gi = gi + 1)
    begin : g_timer_gate
      rlp_clk_gate u_gate (
        .clk     (CLK_SYS),
        .reset_n (RESET_N),
        .en      (timer_run[gi]),
        .gclk    (TIMER_CLK[gi])
      );
    end
  endgenerate

  // bus clock pin: gated so the last pulse before tristate is whole
  rlp_clk_gate u_bus_clk_gate (
    .clk     (CLK_SYS),
    .reset_n (RESET_N),
    .en      (~gate_two_reg[`RLP_G2_BUS_CLK_OFF]),
    .gclk    (BUS_CLK_OUT)
  );

  // the register fabric blocks access to gated peripherals
  always @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      periph_acc_reg <= 7'h7f;
      timer_acc_reg  <= {NUM_TMR{1'b1}};
      port_alt_reg   <= 3'h7;
      bus_clk_oe_reg <= 1'b1;
    end
    else
    begin
      periph_acc_reg <= periph_run;
      timer_acc_reg  <= timer_run;
      port_alt_reg   <= periph_run[6:4];
      bus_clk_oe_reg <= ~gate_two_reg[`RLP_G2_BUS_CLK_OFF];
    end
  end

  // outputs
  assign REG_RD_DATA      = rd_data_reg;
  assign SYS_RESET_N      = sys_rst_n_reg;
  assign PRIMARY_OSC_EN   = osc_en_reg;
  assign SYS_CLK_EN       = sys_clk_en_reg;
  assign CPU_IDLE         = cpu_idle_reg;
  assign PC_FREEZE        = pc_freeze_reg;
  assign OSC32K_EN        = osc32k_en_reg;
  assign RTC_32K_CLK_EN   = rtc_clk_en_reg;
  assign WDT_32K_CLK_EN   = wdt_clk_en_reg;
  assign PERIPH_ACCESS_EN = periph_acc_reg;
  assign TIMER_ACCESS_EN  = timer_acc_reg;
  assign PORT_ALT_FUNC_OK = port_alt_reg;
  assign BUS_CLK_OE       = bus_clk_oe_reg;

endmodule

`default_nettype wire

/* File: bench/rlp_checker.sv */
/* Port checker for the reset, low-power and clock gating block.
   Assumes a bind onto rlp_reset_power with one clock domain. */
`timescale 1ns/100ps
`default_nettype none
module rlp_checker #(
  parameter ADDR_W  = 8,
  parameter NUM_TMR = 6
)
(
  // clock and reset
  input wire logic               CLK_SYS,
  input wire logic               RESET_N,
  // sources and requests
  input wire logic               RST_PIN_N,
  input wire logic               WDT_TIMEOUT,
  input wire logic               RTC_ALARM,
  input wire logic               DBG_RESET,
  input wire logic               SLEEP_INSTRUCTION,
  input wire logic               HALT_INSTRUCTION,
  input wire logic               NMI_REQ,
  input wire logic               INT_REQ,
  // register port
  input wire logic [ADDR_W-1:0]  REG_ADDR,
  input wire logic [7:0]         REG_WR_DATA,
  input wire logic               REG_WR_STB,
  input wire logic               REG_RD_STB,
  input wire logic [7:0]         REG_RD_DATA,
  // power and gating outputs
  input wire logic               SYS_RESET_N,
  input wire logic               PRIMARY_OSC_EN,
  input wire logic               SYS_CLK_EN,
  input wire logic               CPU_IDLE,
  input wire logic               PC_FREEZE,
  input wire logic               OSC32K_EN,
  input wire logic               RTC_32K_CLK_EN,
  input wire logic [6:0]         PERIPH_ACCESS_EN,
  input wire logic [NUM_TMR-1:0] TIMER_ACCESS_EN,
  input wire logic [2:0]         PORT_ALT_FUNC_OK,
  input wire logic               BUS_CLK_OE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);

  a_debug_merge: assert property (DBG_RESET |=> !SYS_RESET_N)
    else $error("debug reset did not assert system reset");
  // only valid while the asynchronous sources stay quiet
  a_stretch_exact: assert property ($fell(DBG_RESET) && !SYS_RESET_N
    && RST_PIN_N |-> ##256 !SYS_RESET_N ##1 SYS_RESET_N)
    else $error("reset stretch length wrong");
  a_sleep_enter: assert property (SLEEP_INSTRUCTION && SYS_RESET_N
    && !CPU_IDLE && !DBG_RESET |=> !PRIMARY_OSC_EN && !SYS_CLK_EN
    && CPU_IDLE && PC_FREEZE)
    else $error("sleep entry wrong");
  a_sleep_osc32: assert property (!SYS_CLK_EN |-> OSC32K_EN
    && RTC_32K_CLK_EN)
    else $error("32k clock stopped in sleep");
  a_sleep_hold: assert property (!SYS_CLK_EN && SYS_RESET_N
    && !DBG_RESET && RST_PIN_N && !RTC_ALARM && !WDT_TIMEOUT
    |=> !SYS_CLK_EN)
    else $error("sleep left without reset");
  a_wake_run: assert property ($fell(SYS_RESET_N) |=> SYS_CLK_EN
    && PRIMARY_OSC_EN && !CPU_IDLE)
    else $error("clocks not restored in reset");
  a_halt_enter: assert property (HALT_INSTRUCTION && !SLEEP_INSTRUCTION
    && SYS_RESET_N && !CPU_IDLE && !DBG_RESET |=> CPU_IDLE && PC_FREEZE
    && SYS_CLK_EN && PRIMARY_OSC_EN)
    else $error("halt entry wrong");
  a_halt_wake: assert property (CPU_IDLE && SYS_CLK_EN
    && (NMI_REQ || INT_REQ) |=> !CPU_IDLE)
    else $error("interrupt did not end halt");
  a_reset_clear: assert property (!SYS_RESET_N [*2] |=>
    &PERIPH_ACCESS_EN && &TIMER_ACCESS_EN && BUS_CLK_OE)
    else $error("gates not cleared by reset");
  a_gate_one: assert property (REG_WR_STB && REG_ADDR == 8'hdb
    && SYS_RESET_N ##1 SYS_RESET_N |=> PERIPH_ACCESS_EN ==
    ~{$past(REG_WR_DATA[7:5], 2), $past(REG_WR_DATA[3:0], 2)}
    && PORT_ALT_FUNC_OK == PERIPH_ACCESS_EN[6:4])
    else $error("first gate register write wrong");
  a_gate_two: assert property (REG_WR_STB && REG_ADDR == 8'hdc
    && SYS_RESET_N ##1 SYS_RESET_N |=> TIMER_ACCESS_EN ==
    ~$past(REG_WR_DATA[5:0], 2) && BUS_CLK_OE == !$past(REG_WR_DATA[7], 2))
    else $error("second gate register write wrong");
  a_reserved_zero: assert property (REG_RD_STB |=>
    !(REG_RD_DATA[4] && $past(REG_ADDR) == 8'hdb)
    && !(REG_RD_DATA[6] && $past(REG_ADDR) == 8'hdc))
    else $error("reserved gate bit read as one");

  cover property (CPU_IDLE && SYS_CLK_EN && INT_REQ);
  cover property (!SYS_CLK_EN ##1 SYS_CLK_EN);
  cover property (REG_WR_STB && REG_ADDR == 8'hdc);
endmodule
`default_nettype wire

/* File: bench/rlp_src_model.sv */
/* Reset sources beside the block: pin, watchdog and alarm.
   Assumes the bench raises the request levels; outputs move off-edge. */
`timescale 1ns/100ps
`default_nettype none
module rlp_src_model
(
  // clock
  input  wire logic clk,
  // requests from the bench
  input  wire logic pin_req,
  input  wire logic wdt_req,
  input  wire logic alarm_req,
  // reset sources
  output var  logic rst_pin_n = 1'b0,
  output var  logic wdt_timeout = 1'b0,
  output var  logic rtc_alarm = 1'b0
);
  int por_cnt = 0;

  // skewed off the edge since these sources are asynchronous
  always @(posedge clk)
  begin
    if (por_cnt < 20)
      por_cnt <= por_cnt + 1;
    rst_pin_n <= #3 (por_cnt >= 19) && !pin_req;
    wdt_timeout <= #3 wdt_req;
    rtc_alarm <= #3 alarm_req;
  end
endmodule
`default_nettype wire

/* File: bench/rlp_reset_power_test.sv */
/* Self-checking bench for rlp_reset_power.
   Assumes rlp_checker and rlp_src_model are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module rlp_reset_power_test;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       pin_req = 1'b0, wdt_req = 1'b0, alarm_req = 1'b0;
  logic       wdt_mode = 1'b1, dbg = 1'b0, sleep_instruction = 1'b0, hlt = 1'b0;
  logic       nmi = 1'b0, irq = 1'b0, wr = 1'b0, rd = 1'b0, w32 = 1'b1;
  logic [7:0] addr = 8'h00, wdat = 8'h00, d1, d2;
  wire        rst_pin_n, wdt_timeout, rtc_alarm, sys_rst_n, osc_en;
  wire        clk_en, idle, frz, osc32, rtc32, wdt32, oe, bclk;
  wire  [7:0] rdat;
  wire  [6:0] pclk, pacc;
  wire  [5:0] tclk, tacc;
  wire  [2:0] alt;
  int         n_fail = 0, checks = 0, seed = 32'h51462472, n;
  int         q[$];

  always #4 clk = ~clk;

  rlp_src_model u_rlp_src_model (.clk(clk), .pin_req(pin_req),
    .wdt_req(wdt_req), .alarm_req(alarm_req), .rst_pin_n(rst_pin_n),
    .wdt_timeout(wdt_timeout), .rtc_alarm(rtc_alarm));

  rlp_reset_power u_rlp_reset_power (.CLK_SYS(clk), .RESET_N(reset_n),
    .RST_PIN_N(rst_pin_n), .WDT_TIMEOUT(wdt_timeout),
    .WDT_RESET_MODE(wdt_mode), .WDT_USES_32K(w32),
    .RTC_ALARM(rtc_alarm), .DBG_RESET(dbg), .SLEEP_INSTRUCTION(sleep_instruction),
    .HALT_INSTRUCTION(hlt), .NMI_REQ(nmi), .INT_REQ(irq),
    .REG_ADDR(addr), .REG_WR_DATA(wdat), .REG_WR_STB(wr),
    .REG_RD_STB(rd), .REG_RD_DATA(rdat), .SYS_RESET_N(sys_rst_n),
    .PRIMARY_OSC_EN(osc_en), .SYS_CLK_EN(clk_en), .CPU_IDLE(idle),
    .PC_FREEZE(frz), .OSC32K_EN(osc32), .RTC_32K_CLK_EN(rtc32),
    .WDT_32K_CLK_EN(wdt32), .PERIPH_CLK(pclk), .TIMER_CLK(tclk),
    .PERIPH_ACCESS_EN(pacc), .TIMER_ACCESS_EN(tacc),
    .PORT_ALT_FUNC_OK(alt), .BUS_CLK_OUT(bclk), .BUS_CLK_OE(oe));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdat <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // expected value queued, then popped at the answer cycle
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdat, q.pop_front());
    @(posedge clk);
  endtask

  task automatic wait_rst(input logic lvl);
    n = 0;
    while (sys_rst_n !== lvl && n < 2000)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk({7'h0, sys_rst_n}, {7'h0, lvl});
    @(posedge clk);
  endtask

  task automatic gate_set(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] e1, e2;
    e1 = a & 8'hef;
    e2 = b & 8'hbf;
    wr_reg(8'hdb, a);
    wr_reg(8'hdc, b);
    rd_chk(8'hdb, e1);
    rd_chk(8'hdc, e2);
    // high phase: a running gated clock shows 1 here
    #1 chk({1'b0, pclk}, {1'b0, ~e1[7:5], ~e1[3:0]});
    chk({2'h0, tclk}, {2'h0, ~e2[5:0]});
    chk({1'b0, pacc}, {1'b0, ~e1[7:5], ~e1[3:0]});
    chk({5'h0, alt}, {5'h0, ~e1[7:5]});
    chk({6'h0, oe, bclk}, {6'h0, ~e2[7], ~e2[7]});
    @(posedge clk);
  endtask

  task wrap_up;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    n_fail++;
    wrap_up;
  end

  initial
  begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    wait_rst(1'b1);
    chk({7'h0, n > 256}, 8'h01);
    rd_chk(8'hdb, 8'h00);
    rd_chk(8'hdc, 8'h00);
    rd_chk(8'h55, 8'h00);
    repeat (6)
    begin
      d1 = $random(seed);
      d2 = $random(seed);
      gate_set(d1, d2);
    end
    for (int w = 0; w < 2; w++)
    begin
      hlt <= 1'b1;
      @(posedge clk);
      hlt <= 1'b0;
      @(posedge clk);
      #1 chk({3'h0, wdt32, idle, frz, clk_en, osc_en}, 8'h1f);
      @(posedge clk);
      nmi <= (w == 0);
      irq <= (w == 1);
      repeat (2) @(posedge clk);
      #1 chk({7'h0, idle}, 8'h00);
      @(posedge clk);
      nmi <= 1'b0;
      irq <= 1'b0;
      @(posedge clk);
    end
    // watchdog off the 32k clock must not end sleep
    w32 <= 1'b0;
    sleep_instruction <= 1'b1;
    @(posedge clk);
    sleep_instruction <= 1'b0;
    irq <= 1'b1;
    wdt_req <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk({3'h0, idle, clk_en, osc_en, osc32, wdt32}, 8'h12);
    chk({7'h0, sys_rst_n}, 8'h01);
    @(posedge clk);
    irq <= 1'b0;
    wdt_req <= 1'b0;
    alarm_req <= 1'b1;
    wait_rst(1'b0);
    chk({5'h0, clk_en, osc_en, idle}, 8'h06);
    alarm_req <= 1'b0;
    wait_rst(1'b1);
    chk({7'h0, n > 250}, 8'h01);
    rd_chk(8'hdc, 8'h00);
    rd_chk(8'hdf, 8'h04);
    for (int k = 0; k < 4; k++)
    begin
      wr_reg(8'hdb, 8'hff);
      wdt_mode <= (k != 3);
      dbg <= (k == 0);
      pin_req <= (k == 1);
      wdt_req <= (k > 1);
      repeat (8) @(posedge clk);
      dbg <= 1'b0;
      pin_req <= 1'b0;
      wdt_req <= 1'b0;
      #1 chk({7'h0, sys_rst_n}, {7'h0, k == 3});
      wait_rst(1'b1);
      chk({7'h0, n > 250}, {7'h0, k != 3});
      rd_chk(8'hdb, (k == 3) ? 8'hef : 8'h00);
      rd_chk(8'hdf, (k == 0) ? 8'h08 : (k == 1) ? 8'h01 : 8'h02);
    end
    wrap_up;
  end
endmodule

bind rlp_reset_power rlp_checker #(.ADDR_W(ADDR_W), .NUM_TMR(NUM_TMR))
  u_rlp_checker (.*);
`default_nettype wire
